// ===== hw/dp_pkg.sv
// constants, field layout and register map of the dataport channel configuration block
// ****************************************************************
// ****************************************************************
package dp_pkg;

  // port count and configuration word
  localparam int NPORT = 10;
  localparam int CFG_W = 24;

  // field positions inside a configuration word
  localparam int F_ACT  = 0;
  localparam int F_DEST = 1;
  localparam int F_TS   = 5;
  localparam int F_FRM  = 10;
  localparam int F_RATE = 12;
  localparam int F_SR   = 15;
  localparam int F_EC   = 20;
  localparam int F_LBD  = 22;
  localparam int F_ERR  = 24;
  localparam int W_ERR  = 5;

  // destination codes
  localparam logic [3:0] DEST_WAN_LAST = 4'h7;
  localparam logic [3:0] DEST_SRV_LAST = 4'hA;
  localparam logic [3:0] DEST_NONE     = 4'hB;

  // framing codes
  localparam logic [1:0] FRM_A   = 2'h0;
  localparam logic [1:0] FRM_B5  = 2'h1;
  localparam logic [1:0] FRM_B10 = 2'h2;
  localparam logic [1:0] FRM_B20 = 2'h3;

  // rate codes
  localparam logic [2:0] RATE_2K4  = 3'h0;
  localparam logic [2:0] RATE_9K6  = 3'h2;
  localparam logic [2:0] RATE_19K2 = 3'h3;
  localparam logic [2:0] RATE_56K  = 3'h4;
  localparam logic [2:0] RATE_64K  = 3'h5;
  localparam logic [2:0] RATE_SW56 = 3'h6;

  // error correction and loopback detect codes
  localparam logic [1:0] EC_OFF  = 2'h0;
  localparam logic [1:0] EC_MAJV = 2'h1;
  localparam logic [1:0] EC_BCH  = 2'h2;
  localparam logic [1:0] LBD_WTO = 2'h0;
  localparam logic [1:0] LBD_OFF = 2'h2;

  // slot and subrate limits
  localparam logic [4:0] TS_MAX_T1  = 5'h18;
  localparam logic [4:0] TS_MAX_E1  = 5'h1F;
  localparam logic [4:0] TS_E1_SIG  = 5'h10;
  localparam logic [4:0] SR_MAX_B5  = 5'h05;
  localparam logic [4:0] SR_MAX_B10 = 5'h0A;
  localparam logic [4:0] SR_MAX_B20 = 5'h14;
  localparam logic [4:0] SR_ONE     = 5'h01;

  // reset word: slot 01 and position 01, all other fields zero
  localparam logic [23:0] CFG_RESET = 24'h008020;

  // register byte offsets
  localparam logic [11:0] A_CTRL    = 12'h000;
  localparam logic [11:0] A_ACTION  = 12'h004;
  localparam logic [11:0] A_STATUS  = 12'h008;
  localparam logic [11:0] A_ELAPSED = 12'h00C;
  localparam logic [11:0] A_PORT0   = 12'h040;

  // control, action and status bits
  localparam int C_E1      = 0;
  localparam int C_SIG     = 1;
  localparam int C_BCH     = 2;
  localparam int CTRL_W    = 3;
  localparam int ACT_SAVE  = 0;
  localparam int ACT_UNDO  = 1;
  localparam int ACT_RFSH  = 2;
  localparam int ACT_LEAVE = 3;
  localparam int S_DIRTY   = 0;
  localparam int S_PROMPT  = 1;
  localparam int S_REFUSED = 2;
  localparam int S_ERR     = 16;

  // timing
  localparam int CLK_HZ           = 50_000_000;
  localparam int SEC_S            = 1;
  localparam int CYC_PER_SEC      = CLK_HZ * SEC_S;
  localparam int LOOP_TIMEOUT_MIN = 10;
  localparam logic [9:0] LOOP_TIMEOUT_SEC = 10'(LOOP_TIMEOUT_MIN * 60);

endpackage

// ===== hw/port_check.sv
// legality check of one port configuration word
`timescale 1ns/1ns
module port_check
  import dp_pkg::*;
(
  // settings under test
  input  wire logic [CFG_W-1:0] cfg,
  input  wire logic [CTRL_W-1:0] ctrl,
  // flags: dest/rate, slot, frame/position, correction, detect mode
  output logic      [W_ERR-1:0] err
);

  logic [3:0] dest;
  logic [4:0] ts;
  logic [1:0] frm;
  logic [2:0] rate;
  logic [4:0] sr;
  logic [1:0] ec;
  logic       srv;
  logic       wan;
  logic [4:0] sr_max;
  logic [4:0] ts_max;

  // field extraction
  assign dest = cfg[F_DEST +: 4];
  assign ts   = cfg[F_TS +: 5];
  assign frm  = cfg[F_FRM +: 2];
  assign rate = cfg[F_RATE +: 3];
  assign sr   = cfg[F_SR +: 5];
  assign ec   = cfg[F_EC +: 2];
  assign wan  = dest <= DEST_WAN_LAST;
  assign srv  = !wan && dest <= DEST_SRV_LAST;

  // per-format limits
  always_comb
  begin
    ts_max = ctrl[C_E1] ? TS_MAX_E1 : TS_MAX_T1;
    unique case (frm)
      FRM_A:   sr_max = SR_ONE;
      FRM_B5:  sr_max = (rate == RATE_19K2) ? SR_MAX_B5 - SR_ONE : SR_MAX_B5;
      FRM_B10: sr_max = SR_MAX_B10;
      FRM_B20: sr_max = SR_MAX_B20;
    endcase
  end

  // offending settings
  always_comb
  begin
    err = '0;
    err[0] = (dest > DEST_NONE) || (rate > RATE_SW56)
      || (srv && rate != RATE_56K && rate != RATE_64K);
    err[1] = wan && (ts == 5'h00 || ts > ts_max
      || (ctrl[C_E1] && ctrl[C_SIG] && ts == TS_E1_SIG));
    err[2] = sr == 5'h00 || sr > sr_max;
    err[3] = (ec > EC_BCH) || (rate == RATE_SW56 && ec != EC_OFF)
      || (ec == EC_MAJV && rate > RATE_9K6)
      || (ec == EC_BCH && !ctrl[C_BCH])
      || (ec == EC_BCH && rate != RATE_19K2 && rate != RATE_56K && rate != RATE_64K);
    err[4] = cfg[F_LBD +: 2] > LBD_OFF;
  end

endmodule

// ===== hw/loop_timer.sv
// remote loopback hold with optional release after the detect time-out
`timescale 1ns/1ns
module loop_timer
  import dp_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // one-second enable and committed detect mode
  input  wire logic       tick_sec,
  input  wire logic [1:0] mode,
  // remote commands, one-cycle pulses
  input  wire logic       loop_up,
  input  wire logic       loop_down,
  // loopback held
  output logic            loop_active
);

  typedef struct packed {
    logic       active;
    logic [9:0] secs;
  } lt_state_t;

  lt_state_t st;
  lt_state_t next_st;

  // loopback hold and timeout count
  always_comb
  begin
    next_st = st;
    if (mode == LBD_OFF)
      next_st.active = 1'b0;
    else if (loop_up)
    begin
      next_st.active = 1'b1;
      next_st.secs   = '0;
    end
    else if (loop_down)
      next_st.active = 1'b0;
    else if (st.active && mode == LBD_WTO && tick_sec)
    begin
      if (st.secs == LOOP_TIMEOUT_SEC - 10'h001)
        next_st.active = 1'b0;
      else
        next_st.secs = st.secs + 10'h001;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign loop_active = st.active;

endmodule

// ===== hw/dataport_channel_config.sv
// register bank, commit and revert logic for the ten-port dataport unit
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module dataport_channel_config
  import dp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CYC_PER_SEC
)
(
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // remote loopback commands per port
  input  wire logic [NPORT-1:0]            remote_loop_up,
  input  wire logic [NPORT-1:0]            remote_loop_down,
  // committed configuration per port
  output logic      [NPORT-1:0][CFG_W-1:0] port_config,
  output logic      [NPORT-1:0]            slot_claim,
  output logic      [NPORT-1:0]            loop_active,
  // operator prompt
  output logic                             config_prompt
);

  // ****************************************************************
  // state
  // ****************************************************************

  typedef struct packed {
    logic [NPORT-1:0][CFG_W-1:0] pend;
    logic [NPORT-1:0][CFG_W-1:0] comm;
    logic [NPORT-1:0]            claim;
    logic [CTRL_W-1:0]           ctrl;
    logic                        prompt;
    logic                        refused;
    logic [31:0]                 div;
    logic [31:0]                 secs;
    logic [31:0]                 snap;
    logic [31:0]                 rdata;
    logic                        rerr;
  } cfg_state_t;

  cfg_state_t st;
  cfg_state_t next_st;

  logic [NPORT-1:0][W_ERR-1:0] perr;
  logic [NPORT-1:0]            port_bad;
  logic                        any_bad;
  logic                        dirty;
  logic                        tick_sec;
  logic                        setup;
  logic                        wr_acc;
  logic                        aligned;
  logic                        port_hit;
  logic [3:0]                  idx;
  logic                        mapped;
  logic [31:0]                 rd_mux;
  logic [31:0]                 status_word;

  // ****************************************************************
  // per-port checks and loopback holds
  // ****************************************************************

  // one checker on each pending word, one hold on each committed mode
  generate
    for (genvar i = 0; i < NPORT; i++)
    begin : g_port
      port_check u_chk (
        .cfg  (st.pend[i]),
        .ctrl (st.ctrl),
        .err  (perr[i])
      );

      loop_timer u_loop (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick_sec    (tick_sec),
        .mode        (st.comm[i][F_LBD +: 2]),
        .loop_up     (remote_loop_up[i]),
        .loop_down   (remote_loop_down[i]),
        .loop_active (loop_active[i])
      );

      assign port_bad[i] = |perr[i];
    end
  endgenerate

  // ****************************************************************
  // decode
  // ****************************************************************

  // summary flags
  assign any_bad  = |port_bad;
  assign dirty    = st.pend != st.comm;
  assign tick_sec = st.div == 32'(TICK_CYCLES - 1);

  // apb phases and address decode
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && !st.rerr;
  assign aligned  = paddr[1:0] == 2'h0;
  assign idx      = paddr[5:2];
  assign port_hit = paddr[11:6] == A_PORT0[11:6] && idx < 4'(NPORT);
  assign mapped   = aligned && (port_hit || paddr == A_CTRL || paddr == A_ACTION
                    || paddr == A_STATUS || paddr == A_ELAPSED);

  // status word
  always_comb
  begin
    status_word = '0;
    status_word[S_DIRTY]   = dirty;
    status_word[S_PROMPT]  = st.prompt;
    status_word[S_REFUSED] = st.refused;
    status_word[S_ERR +: NPORT] = port_bad;
  end

  // read data selection, sampled in the setup cycle
  always_comb
  begin
    rd_mux = '0;
    if (port_hit && aligned)
      rd_mux = {3'h0, perr[idx], st.pend[idx]};
    else if (paddr == A_CTRL)
      rd_mux = {29'h0, st.ctrl};
    else if (paddr == A_STATUS)
      rd_mux = status_word;
    else if (paddr == A_ELAPSED)
      rd_mux = st.snap;
  end

  // ****************************************************************
  // next state
  // ****************************************************************

  always_comb
  begin
    next_st = st;

    // one-second enable and running seconds count
    next_st.div = tick_sec ? 32'h0 : st.div + 32'h1;
    if (tick_sec)
      next_st.secs = st.secs + 32'h1;

    // read capture and error decision at setup
    if (setup)
    begin
      next_st.rdata = mapped ? rd_mux : 32'h0;
      next_st.rerr  = !mapped;
    end

    // register writes in the access cycle
    if (wr_acc)
    begin
      if (port_hit)
        next_st.pend[idx] = pwdata[CFG_W-1:0];
      else if (paddr == A_CTRL)
        next_st.ctrl = pwdata[CTRL_W-1:0];
      else if (paddr == A_ACTION)
      begin
        if (pwdata[ACT_SAVE])
        begin
          if (any_bad)
            next_st.refused = 1'b1;
          else
          begin
            next_st.comm    = st.pend;
            next_st.refused = 1'b0;
            next_st.prompt  = 1'b0;
            for (int i = 0; i < NPORT; i++)
            begin
              next_st.claim[i] = st.pend[i][F_ACT]
                && st.pend[i][F_DEST +: 4] <= DEST_WAN_LAST;
            end
          end
        end
        else if (pwdata[ACT_UNDO])
        begin
          next_st.pend   = st.comm;
          next_st.prompt = 1'b0;
        end
        if (pwdata[ACT_RFSH])
          next_st.snap = st.secs;
        if (pwdata[ACT_LEAVE] && dirty)
          next_st.prompt = 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st      <= '0;
      st.pend <= {NPORT{CFG_RESET}};
      st.comm <= {NPORT{CFG_RESET}};
    end
    else
      st <= next_st;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // zero wait states; data and error prepared in setup
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && st.rerr;
  assign prdata        = st.rdata;
  assign port_config   = st.comm;
  assign slot_claim    = st.claim;
  assign config_prompt = st.prompt;

endmodule

// ===== tb/dataport_channel_config_monitor.sv
// assertion checker watching the ports of the dataport configuration block
`timescale 1ns/1ns
module dataport_channel_config_monitor
  import dp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4
)
(
  // clock, reset and apb
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [11:0]                 paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // loopback commands and committed state
  input wire logic [NPORT-1:0]            remote_loop_up,
  input wire logic [NPORT-1:0]            remote_loop_down,
  input wire logic [NPORT-1:0][CFG_W-1:0] port_config,
  input wire logic [NPORT-1:0]            slot_claim,
  input wire logic [NPORT-1:0]            loop_active,
  input wire logic                        config_prompt
);
  // longest legal timed hold, with slack for a partial first tick
  localparam int LIM = 601 * TICK_CYCLES + 4;
  logic [NPORT-1:0] claim, srv, majv, sw56, bch;
  int               cnt;

  // per-port view of the committed words
  always_comb
  begin
    for (int i = 0; i < NPORT; i++)
    begin
      claim[i] = port_config[i][0] && port_config[i][4:1] <= DEST_WAN_LAST;
      srv[i]   = port_config[i][4:1] > DEST_WAN_LAST && port_config[i][4:1] <= DEST_SRV_LAST
                 && !(port_config[i][14:12] inside {RATE_56K, RATE_64K});
      majv[i]  = port_config[i][21:20] == EC_MAJV && port_config[i][14:12] > RATE_9K6;
      sw56[i]  = port_config[i][14:12] == RATE_SW56 && port_config[i][21:20] != EC_OFF;
      bch[i]   = port_config[i][21:20] == EC_BCH
                 && !(port_config[i][14:12] inside {RATE_19K2, RATE_56K, RATE_64K});
    end
  end

  // cycles that port 0 has held a timed loopback since its last loop-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 0;
    else if (!loop_active[0] || remote_loop_up[0] || port_config[0][23:22] != LBD_WTO)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_claim;
    slot_claim == claim;
  endproperty
  a_claim: assert property (p_claim)
    else $error("slot claim disagrees with committed state");
  property p_srv;
    srv == '0;
  endproperty
  a_srv: assert property (p_srv)
    else $error("server port committed at a wrong rate");
  property p_majv;
    majv == '0;
  endproperty
  a_majv: assert property (p_majv)
    else $error("majority vote committed above 9.6");
  property p_sw56;
    sw56 == '0;
  endproperty
  a_sw56: assert property (p_sw56)
    else $error("correction committed at switched rate");
  property p_bch;
    bch == '0;
  endproperty
  a_bch: assert property (p_bch)
    else $error("bch committed at a wrong rate");
  property p_unmapped;
    psel && penable && paddr == A_PORT0 + 12'h028 |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("eleventh port slot not refused");
  property p_loop_set;
    port_config[0][23:22] != LBD_OFF && remote_loop_up[0] && !remote_loop_down[0]
      |=> loop_active[0];
  endproperty
  a_loop_set: assert property (p_loop_set)
    else $error("loop-up not taken");
  property p_loop_off;
    port_config[2][23:22] == LBD_OFF ##1 port_config[2][23:22] == LBD_OFF |-> !loop_active[2];
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loopback held with detection off");
  property p_undo;
    psel && penable && pwrite && paddr == A_ACTION && pwdata[1:0] == 2'h2 |=> !config_prompt;
  endproperty
  a_undo: assert property (p_undo)
    else $error("prompt survives undo");
  property p_timeout;
    cnt <= LIM;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timed loopback not released");

  // main scenarios reached
  c_claim: cover property (slot_claim[1]);
  c_prompt: cover property (config_prompt);
  c_release: cover property (loop_active[0] ##1 !loop_active[0]);
endmodule

// ===== tb/dataport_channel_config_tb.sv
// self-checking bench for the dataport configuration block
`timescale 1ns/1ns
module dataport_channel_config_tb
  import dp_pkg::*;
;
  localparam int unsigned TICK = 4;
  logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                        config_prompt;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata, rd, e0, tbl [16];
  logic [23:0]                 exp_c, w0, w1, w2;
  logic [NPORT-1:0]            loop_up, loop_dn, slot_claim, loop_active;
  logic [NPORT-1:0][CFG_W-1:0] port_config;
  int                          n_fail = 0;
  int                          tests_run = 0;

  dataport_channel_config #(.TICK_CYCLES(TICK)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_loop_up(loop_up), .remote_loop_down(loop_dn), .port_config(port_config),
    .slot_claim(slot_claim), .loop_active(loop_active), .config_prompt(config_prompt)
  );

  // 50 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [23:0] mk(input logic [3:0] ds, input logic [4:0] ts,
    input logic [1:0] fr, input logic [2:0] rt, input logic [4:0] sr, input logic [1:0] ec);
    return {2'h0, ec, sr, rt, fr, ts, ds, 1'b0};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; read data lands in rd
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the slave however long it takes; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic act(input logic [3:0] b);
    apb(1'b1, A_ACTION, {28'h0, b});
    @(negedge pclk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    finish_test();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, loop_up, loop_dn, presetn} = '0;
    w0 = mk(4'h0, 5'h01, 2'h0, 3'h0, 5'h01, 2'h0);
    w1 = mk(4'h3, 5'h18, 2'h0, 3'h3, 5'h01, 2'h0) | 24'h400001;
    w2 = mk(4'h8, 5'h01, 2'h0, 3'h5, 5'h01, 2'h0) | 24'h800001;
    // ctrl, expected error flags, pending word
    tbl = '{{3'h0, 5'h01, mk(4'h9, 5'h01, 2'h0, 3'h2, 5'h01, 2'h0)},
            {3'h0, 5'h01, mk(4'hC, 5'h01, 2'h0, 3'h0, 5'h01, 2'h0)},
            {3'h0, 5'h02, mk(4'h0, 5'h19, 2'h0, 3'h0, 5'h01, 2'h0)},
            {3'h3, 5'h02, mk(4'h0, 5'h10, 2'h0, 3'h0, 5'h01, 2'h0)},
            {3'h1, 5'h00, mk(4'h0, 5'h1F, 2'h0, 3'h0, 5'h01, 2'h0)},
            {3'h0, 5'h04, mk(4'h0, 5'h01, 2'h1, 3'h2, 5'h06, 2'h0)},
            {3'h0, 5'h04, mk(4'h0, 5'h01, 2'h1, 3'h3, 5'h05, 2'h0)},
            {3'h0, 5'h00, mk(4'h0, 5'h01, 2'h3, 3'h1, 5'h14, 2'h1)},
            {3'h0, 5'h08, mk(4'h0, 5'h01, 2'h0, 3'h3, 5'h01, 2'h1)},
            {3'h0, 5'h08, mk(4'h0, 5'h01, 2'h0, 3'h6, 5'h01, 2'h1)},
            {3'h0, 5'h08, mk(4'h0, 5'h01, 2'h0, 3'h5, 5'h01, 2'h2)},
            {3'h4, 5'h08, mk(4'h0, 5'h01, 2'h0, 3'h2, 5'h01, 2'h2)},
            {3'h4, 5'h00, mk(4'h0, 5'h01, 2'h2, 3'h4, 5'h0A, 2'h2)},
            {3'h0, 5'h01, mk(4'h0, 5'h01, 2'h0, 3'h7, 5'h01, 2'h0)},
            {3'h0, 5'h00, mk(4'h0, 5'h01, 2'h0, 3'h6, 5'h01, 2'h0)},
            {3'h0, 5'h10, w0 | 24'hC00000}};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // defaults of all ten ports, then the slot past the last port
    for (int i = 0; i < NPORT; i++)
    begin
      apb(1'b0, A_PORT0 + 12'(4 * i), '0);
      check("port_read", rd, {8'h0, w0});
      check("port_config", {8'h0, port_config[i]}, {8'h0, w0});
    end
    apb(1'b0, A_PORT0 + 12'h028, '0);
    check("port_ten", rd, '0);
    check("claim_idle", {22'h0, slot_claim}, '0);
    $display("test reset done");
    // active wan port claims, active server port does not
    apb(1'b1, A_PORT0 + 12'h004, {8'h0, w1});
    apb(1'b1, A_PORT0 + 12'h008, {8'h0, w2});
    act(4'h1);
    check("claim", {22'h0, slot_claim}, 32'h002);
    check("server_cfg", {8'h0, port_config[2]}, {8'h0, w2});
    $display("test commit done");
    // legality table on port 3
    exp_c = w0;
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, A_CTRL, {29'h0, tbl[i][31:29]});
      apb(1'b1, A_PORT0 + 12'h00C, {8'h0, tbl[i][23:0]});
      apb(1'b0, A_PORT0 + 12'h00C, '0);
      check("flags", rd, {3'h0, tbl[i][28:0]});
      act(4'h1);
      if (tbl[i][28:24] == 5'h00)
        exp_c = tbl[i][23:0];
      apb(1'b0, A_STATUS, '0);
      check("refused", {30'h0, rd[19], rd[2]}, {30'h0, {2{|tbl[i][28:24]}}});
      check("committed", {8'h0, port_config[3]}, {8'h0, exp_c});
    end
    $display("test legality done");
    // leave prompt, undo and save over undo
    apb(1'b1, A_PORT0 + 12'h010, {8'h0, w2});
    act(4'h8);
    check("prompt_set", {31'h0, config_prompt}, 32'h1);
    apb(1'b0, A_STATUS, '0);
    check("status", {30'h0, rd[1:0]}, 32'h3);
    act(4'h2);
    check("prompt_undo", {31'h0, config_prompt}, '0);
    apb(1'b0, A_PORT0 + 12'h010, '0);
    check("undo", rd, {8'h0, w0});
    act(4'h8);
    check("prompt_clean", {31'h0, config_prompt}, '0);
    apb(1'b1, A_PORT0 + 12'h010, {8'h0, w2});
    act(4'h3);
    check("save_first", {8'h0, port_config[4]}, {8'h0, w2});
    $display("test save undo done");
    // elapsed seconds move only on refresh
    apb(1'b0, A_ELAPSED, '0);
    e0 = rd;
    repeat (40) @(posedge pclk);
    apb(1'b0, A_ELAPSED, '0);
    check("elapsed_held", rd, e0);
    act(4'h4);
    apb(1'b0, A_ELAPSED, '0);
    check("elapsed_moved", {31'h0, rd > e0}, 32'h1);
    $display("test refresh done");
    // ports 0, 1, 2 detect with time-out, on, off
    @(posedge pclk);
    loop_up <= 10'h007;
    @(posedge pclk);
    loop_up <= 10'h000;
    @(negedge pclk);
    check("loop_set", {29'h0, loop_active[2:0]}, 32'h3);
    repeat (598 * TICK) @(posedge pclk);
    @(negedge pclk);
    check("loop_hold", {29'h0, loop_active[2:0]}, 32'h3);
    repeat (4 * TICK) @(posedge pclk);
    @(negedge pclk);
    check("loop_expire", {29'h0, loop_active[2:0]}, 32'h2);
    @(posedge pclk);
    loop_dn <= 10'h002;
    @(posedge pclk);
    loop_dn <= 10'h000;
    @(negedge pclk);
    check("loop_down", {29'h0, loop_active[2:0]}, '0);
    $display("test loopback done");
    finish_test();
  end
endmodule

bind dataport_channel_config dataport_channel_config_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .remote_loop_up(remote_loop_up), .remote_loop_down(remote_loop_down),
  .port_config(port_config), .slot_claim(slot_claim), .loop_active(loop_active),
  .config_prompt(config_prompt)
);
